// >>> rtl/osw_pkg.sv
// Summary of operation
// - tuning field is signed; 000000 centre, 100000 minimum
// - tuning field ignores software writes during self-tune
// - self-tune bit 15 steers tuning from reference
// - software may select any of six sources
// - primary submode fixed by straps, never switched
// - unprogrammed straps disable switching and fail monitor
// - disabled switching ignores new source, reports initial
// - disabled switching holds switch request at zero
// - equal current and new source aborts switch
// - valid switch clears lock and fail flags
// - start new source, await start-up or lock
// - count ten new clock cycles before changeover
// - changeover clears request, copies new to current
// - stop old source, except kept low-power or secondary
// - processor keeps running during the whole switch
package osw_pkg;

   // register port geometry, byte wide
   localparam int ADDR_W = 2;
   localparam int DATA_W = 8;

   // byte addresses of the two 16-bit registers
   localparam logic [1:0] ADDR_CTRL_LO = 2'h0;
   localparam logic [1:0] ADDR_CTRL_HI = 2'h1;
   localparam logic [1:0] ADDR_TUNE_LO = 2'h2;
   localparam logic [1:0] ADDR_TUNE_HI = 2'h3;

   // unlock keys
   localparam logic [7:0] KEY_HI_1 = 8'h78;
   localparam logic [7:0] KEY_HI_2 = 8'h9A;
   localparam logic [7:0] KEY_LO_1 = 8'h46;
   localparam logic [7:0] KEY_LO_2 = 8'h57;

   // control and tuning register fields, positions inside their byte
   localparam int REQ_BIT     = 0;   // bit 0
   localparam int SECONDARY_OSC_EN_BIT = 1;   // bit 1
   localparam int CF_BIT      = 3;   // bit 3
   localparam int LOCK_BIT    = 5;   // bit 5
   localparam int NEW_LSB     = 0;   // bits 10:8
   localparam int CUR_LSB     = 4;   // bits 14:12
   localparam int SELF_TUNE_ENABLE_BIT    = 7;   // tuning bit 15

   // source selection codes
   localparam int SRC_W = 3;
   localparam logic [2:0] SRC_FRC     = 3'h0;
   localparam logic [2:0] SRC_FRC_PLL = 3'h1;
   localparam logic [2:0] SRC_PRI     = 3'h2;
   localparam logic [2:0] SRC_PRI_PLL = 3'h3;
   localparam logic [2:0] SRC_SEC     = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER_RC    = 3'h5;

   // oscillator enable vector positions
   localparam int N_OSC    = 4;
   localparam int OSC_FRC  = 0;
   localparam int OSC_PRI  = 1;
   localparam int OSC_SEC  = 2;
   localparam int OSC_LOW_POWER_RC = 3;

   // strap encodings
   localparam logic [1:0] SUB_EC     = 2'h0;  // external clock, no start-up timer
   localparam int         CFG_SW_OFF = 1;     // strap bit that disables switching
   localparam logic [1:0] CFG_MON_ON = 2'h0;  // switching and fail monitor on
   localparam logic [1:0] CFG_WAIT   = 2'h3;  // cycles before straps are trusted

   // tuning field
   localparam int TUNE_W = 6;
   localparam logic [5:0] TUNE_CENTRE = 6'h00;
   localparam logic [5:0] TUNE_MIN    = 6'h20;
   localparam logic [5:0] TUNE_MAX    = 6'h1F;

   // changeover delay in new clock cycles
   localparam int NEW_CLK_CYCLES = 10;
   localparam int CNT_W          = 4;

   typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_WAIT, ST_COUNT, ST_DONE} osw_state_t;
   typedef enum logic [1:0] {KEY_IDLE, KEY_ONE, KEY_OPEN} osw_key_t;

endpackage

// >>> rtl/osw_sync.sv
`timescale 1ns/100ps
// two flip-flop synchroniser for pin levels
module osw_sync
   import osw_pkg::*;
#(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         i_clk_sys,
   input  wire logic         i_reset,
   // pin side and synchronised side
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);

   logic [W-1:0] meta_reg;  // first stage, read only by second stage

   // two stages, nothing taps the first
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         meta_reg <= '0;
         o_q      <= '0;
      end else begin
         meta_reg <= i_d;
         o_q      <= meta_reg;
      end
   end

endmodule // osw_sync

// >>> rtl/osw_osc_switch.sv
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/100ps
// oscillator selection, unlock and changeover controller
module osw_osc_switch
   import osw_pkg::*;
#(
   parameter int unsigned NEW_CLK_COUNT = NEW_CLK_CYCLES
) (
   // clock and reset
   input  wire logic              i_clk_sys,
   input  wire logic              i_reset,
   // register port
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DATA_W-1:0] o_rdata,
   // configuration straps
   input  wire logic [1:0]        i_switch_monitor_cfg,
   input  wire logic [SRC_W-1:0]  i_initial_source_cfg,
   input  wire logic [1:0]        i_primary_submode_cfg,
   input  wire logic              i_watchdog_en,
   // oscillator status pins
   input  wire logic [N_OSC-1:0]  i_osc_stable,
   input  wire logic              i_pll_lock,
   input  wire logic              i_new_clk,
   input  wire logic              i_clk_fail,
   input  wire logic              i_tune_up,
   input  wire logic              i_tune_dn,
   // oscillator control
   output logic      [SRC_W-1:0]  o_clk_sel,
   output logic      [SRC_W-1:0]  o_new_clk_sel,
   output logic      [N_OSC-1:0]  o_osc_en,
   output logic                   o_pll_en,
   output logic      [1:0]        o_primary_submode,
   output logic      [TUNE_W-1:0] o_rc_tune,
   output logic                   o_switch_busy
);

   localparam int SYN_W = N_OSC + 13;

   // source decode helpers
   function automatic logic [N_OSC-1:0] osc_of(input logic [SRC_W-1:0] s);
      logic [N_OSC-1:0] v;
      v = '0;
      unique case (s)
         SRC_PRI, SRC_PRI_PLL: v[OSC_PRI] = 1'b1;
         SRC_SEC:              v[OSC_SEC] = 1'b1;
         SRC_LOW_POWER_RC:             v[OSC_LOW_POWER_RC] = 1'b1;
         default:              v[OSC_FRC] = 1'b1;
      endcase
      return v;
   endfunction

   function automatic logic uses_pll(input logic [SRC_W-1:0] s);
      return (s == SRC_FRC_PLL) || (s == SRC_PRI_PLL);
   endfunction

   // next key state for one protected byte
   function automatic osw_key_t key_next(input osw_key_t st, input logic hit,
                                         input logic [7:0] d, input logic [7:0] k1,
                                         input logic [7:0] k2);
      if (st == KEY_OPEN || !hit)
         return KEY_IDLE;
      else if (st == KEY_ONE && d == k2)
         return KEY_OPEN;
      else if (d == k1)
         return KEY_ONE;
      else
         return KEY_IDLE;
   endfunction

   // synchronised pins
   logic [SYN_W-1:0]  syn_in;
   logic [SYN_W-1:0]  syn_q;
   logic [N_OSC-1:0]  stable_s;      // start-up timers expired
   logic              lock_s;        // pll locked
   logic              newclk_s;      // new source clock level
   logic              fail_s;        // fail monitor event
   logic              up_s;          // reference says faster
   logic              dn_s;          // reference says slower
   logic [1:0]        swcfg_s;       // switching strap
   logic [SRC_W-1:0]  init_s;        // initial source strap
   logic [1:0]        sub_s;         // primary submode strap
   logic              wdt_s;         // watchdog running

   assign syn_in = {i_osc_stable, i_pll_lock, i_new_clk, i_clk_fail, i_tune_up,
                    i_tune_dn, i_switch_monitor_cfg, i_initial_source_cfg,
                    i_primary_submode_cfg, i_watchdog_en};
   assign {stable_s, lock_s, newclk_s, fail_s, up_s, dn_s, swcfg_s, init_s,
           sub_s, wdt_s} = syn_q;

   osw_sync #(.W(SYN_W)) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_d       (syn_in),
      .o_q       (syn_q)
   );

   // edge detect memories, fed from second stage only
   logic        newclk_q_reg;
   logic        lock_q_reg;
   logic        fail_q_reg;
   logic        up_q_reg;
   logic        dn_q_reg;
   logic        newclk_rise;
   logic        lock_rise;
   logic        fail_rise;
   logic        up_rise;
   logic        dn_rise;

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         newclk_q_reg <= 1'b0;
         lock_q_reg   <= 1'b0;
         fail_q_reg   <= 1'b0;
         up_q_reg     <= 1'b0;
         dn_q_reg     <= 1'b0;
      end else begin
         newclk_q_reg <= newclk_s;
         lock_q_reg   <= lock_s;
         fail_q_reg   <= fail_s;
         up_q_reg     <= up_s;
         dn_q_reg     <= dn_s;
      end
   end

   assign newclk_rise = newclk_s & ~newclk_q_reg;
   assign lock_rise   = lock_s & ~lock_q_reg;
   assign fail_rise   = fail_s & ~fail_q_reg;
   assign up_rise     = up_s & ~up_q_reg;
   assign dn_rise     = dn_s & ~dn_q_reg;

   // strap capture, a few cycles after release
   logic [1:0]  cfg_cnt_reg;     // settle counter
   logic        cfg_ready_reg;   // straps captured
   logic        cfg_load;        // capture cycle
   logic        sw_en_reg;       // switching allowed
   logic        mon_en_reg;      // fail monitor allowed

   assign cfg_load = !cfg_ready_reg && (cfg_cnt_reg == CFG_WAIT);

   // straps are static, so sampling once avoids mid-run surprises
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         cfg_cnt_reg       <= '0;
         cfg_ready_reg     <= 1'b0;
         sw_en_reg         <= 1'b0;
         mon_en_reg        <= 1'b0;
         o_primary_submode <= SUB_EC;
      end else if (!cfg_ready_reg) begin
         cfg_cnt_reg <= cfg_cnt_reg + 2'h1;
         if (cfg_load) begin
            cfg_ready_reg     <= 1'b1;
            sw_en_reg         <= !swcfg_s[CFG_SW_OFF];
            mon_en_reg        <= (swcfg_s == CFG_MON_ON);
            o_primary_submode <= sub_s;
         end
      end
   end

   // write decode
   logic        wr_ctrl_lo;
   logic        wr_ctrl_hi;
   logic        wr_tune_lo;
   logic        wr_tune_hi;
   osw_key_t    hi_key_reg;      // high byte unlock progress
   osw_key_t    lo_key_reg;      // low byte unlock progress
   logic        hi_accept;       // high byte data write taken
   logic        lo_accept;       // low byte data write taken

   assign wr_ctrl_lo = i_wr && (i_addr == ADDR_CTRL_LO);
   assign wr_ctrl_hi = i_wr && (i_addr == ADDR_CTRL_HI);
   assign wr_tune_lo = i_wr && (i_addr == ADDR_TUNE_LO);
   assign wr_tune_hi = i_wr && (i_addr == ADDR_TUNE_HI);
   // only the write right after keys
   assign hi_accept  = wr_ctrl_hi && (hi_key_reg == KEY_OPEN);
   assign lo_accept  = wr_ctrl_lo && (lo_key_reg == KEY_OPEN);

   // key sequencers; any other write relocks both bytes
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         hi_key_reg <= KEY_IDLE;
         lo_key_reg <= KEY_IDLE;
      end else if (i_wr) begin
         hi_key_reg <= key_next(hi_key_reg, wr_ctrl_hi, i_wdata, KEY_HI_1, KEY_HI_2);
         lo_key_reg <= key_next(lo_key_reg, wr_ctrl_lo, i_wdata, KEY_LO_1, KEY_LO_2);
      end
   end

   // control register state
   osw_state_t        state_reg;
   logic [SRC_W-1:0]  cur_reg;      // current source
   logic [SRC_W-1:0]  new_reg;      // requested source
   logic [SRC_W-1:0]  tgt_reg;      // source being switched to
   logic              req_reg;      // switch request
   logic              secondary_osc_en_reg;  // keep secondary running
   logic              lock_reg;     // pll lock status
   logic              cf_reg;       // clock fail flag
   logic [CNT_W-1:0]  cnt_reg;      // new clock edges seen
   logic              tgt_ready;    // target source usable
   logic              redundant;    // requested equals current
   logic              last_edge;    // final counted edge

   assign redundant = (new_reg == cur_reg);
   assign last_edge = newclk_rise && (cnt_reg == CNT_W'(NEW_CLK_COUNT - 1));

   // crystal waits start-up, pll waits lock
   always_comb begin
      if (uses_pll(tgt_reg))
         tgt_ready = lock_s;
      else if (tgt_reg == SRC_SEC)
         tgt_ready = stable_s[OSC_SEC];
      else if (tgt_reg == SRC_PRI && o_primary_submode != SUB_EC)
         tgt_ready = stable_s[OSC_PRI];
      else
         tgt_ready = 1'b1;
   end

   // high byte fields; new source stored but ignored if switching is off
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         new_reg <= SRC_FRC;
      end else if (cfg_load) begin
         new_reg <= init_s;
      end else if (hi_accept) begin
         new_reg <= i_wdata[NEW_LSB +: SRC_W];
      end
   end

   // secondary keep-alive bit
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         secondary_osc_en_reg <= 1'b0;
      end else if (lo_accept) begin
         secondary_osc_en_reg <= i_wdata[SECONDARY_OSC_EN_BIT];
      end
   end

   // switch request: set by software, cleared by hardware only
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         req_reg <= 1'b0;
      end else if (lo_accept && i_wdata[REQ_BIT] && sw_en_reg && state_reg == ST_IDLE) begin
         req_reg <= 1'b1;
      end else if (state_reg == ST_CHECK && redundant) begin
         req_reg <= 1'b0;
      end else if (state_reg == ST_DONE) begin
         req_reg <= 1'b0;
      end
   end

   // switch sequencer; the core is never stalled meanwhile
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         state_reg <= ST_IDLE;
         tgt_reg   <= SRC_FRC;
         cnt_reg   <= '0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (req_reg) begin
                  state_reg <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               tgt_reg   <= new_reg;
               state_reg <= redundant ? ST_IDLE : ST_WAIT;
            end
            ST_WAIT: begin
               cnt_reg <= '0;
               if (tgt_ready) begin
                  state_reg <= ST_COUNT;
               end
            end
            ST_COUNT: begin
               if (last_edge) begin
                  state_reg <= ST_DONE;
               end else if (newclk_rise) begin
                  cnt_reg <= cnt_reg + CNT_W'(1);
               end
            end
            ST_DONE: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // current source: strap at start, target at changeover
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         cur_reg <= SRC_FRC;
      end else if (cfg_load) begin
         cur_reg <= init_s;
      end else if (state_reg == ST_DONE) begin
         cur_reg <= tgt_reg;
      end
   end

   // status flags; a new event beats the clear
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         lock_reg <= 1'b0;
         cf_reg   <= 1'b0;
      end else begin
         if (lock_rise)
            lock_reg <= 1'b1;
         else if (state_reg == ST_CHECK && !redundant)
            lock_reg <= 1'b0;
         if (fail_rise && mon_en_reg)
            cf_reg <= 1'b1;
         else if (state_reg == ST_CHECK && !redundant)
            cf_reg <= 1'b0;
      end
   end

   // oscillator enables: current, target while busy, kept sources
   logic             busy;
   logic [N_OSC-1:0] en_next;

   assign busy = (state_reg != ST_IDLE);

   always_comb begin
      en_next = osc_of(cur_reg);
      if (busy)
         en_next = en_next | osc_of(tgt_reg);
      if (wdt_s || mon_en_reg)
         en_next[OSC_LOW_POWER_RC] = 1'b1;
      if (secondary_osc_en_reg)
         en_next[OSC_SEC] = 1'b1;
   end

   // registered oscillator controls
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_osc_en      <= '0;
         o_pll_en      <= 1'b0;
         o_new_clk_sel <= SRC_FRC;
         o_switch_busy <= 1'b0;
      end else begin
         o_osc_en      <= en_next;
         o_pll_en      <= uses_pll(cur_reg) || (busy && uses_pll(tgt_reg));
         o_new_clk_sel <= busy ? tgt_reg : cur_reg;
         o_switch_busy <= busy;
      end
   end

   assign o_clk_sel = cur_reg;

   // tuning register: signed field, hardware owns it in self-tune
   logic              self_tune_enable_reg;    // self-tune enable
   logic [TUNE_W-1:0] tune_reg;    // signed tuning offset

   assign o_rc_tune = tune_reg;

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         self_tune_enable_reg <= 1'b0;
         tune_reg <= TUNE_CENTRE;
      end else begin
         if (wr_tune_hi)
            self_tune_enable_reg <= i_wdata[SELF_TUNE_ENABLE_BIT];
         if (self_tune_enable_reg) begin
            if (up_rise && !dn_rise && tune_reg != TUNE_MAX)
               tune_reg <= tune_reg + TUNE_W'(1);
            else if (dn_rise && !up_rise && tune_reg != TUNE_MIN)
               tune_reg <= tune_reg - TUNE_W'(1);
         end else if (wr_tune_lo) begin
            tune_reg <= i_wdata[TUNE_W-1:0];
         end
      end
   end

   // read mux; data stand only in the cycle after the strobe
   logic [DATA_W-1:0] rd_next;

   always_comb begin
      rd_next = '0;
      unique case (i_addr)
         ADDR_CTRL_LO: begin
            rd_next[REQ_BIT]     = req_reg;
            rd_next[SECONDARY_OSC_EN_BIT] = secondary_osc_en_reg;
            rd_next[CF_BIT]      = cf_reg;
            rd_next[LOCK_BIT]    = lock_reg;
         end
         ADDR_CTRL_HI: begin
            rd_next[NEW_LSB +: SRC_W] = new_reg;
            rd_next[CUR_LSB +: SRC_W] = cur_reg;
         end
         ADDR_TUNE_LO: rd_next[TUNE_W-1:0] = tune_reg;
         ADDR_TUNE_HI: rd_next[SELF_TUNE_ENABLE_BIT]   = self_tune_enable_reg;
      endcase
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset)
         o_rdata <= '0;
      else
         o_rdata <= i_rd ? rd_next : '0;
   end

   // checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);

   chk_req_held_low: assert property (
      !sw_en_reg |-> !req_reg) else $error("request set while switching off");
   chk_cur_is_strap: assert property (
      $past(cfg_ready_reg) && !sw_en_reg |-> cur_reg == $past(cur_reg))
      else $error("current source moved while switching off");
   chk_redundant_abort: assert property (
      state_reg == ST_CHECK && redundant |=> state_reg == ST_IDLE && !req_reg)
      else $error("redundant switch not aborted");
   chk_flags_cleared: assert property (
      state_reg == ST_CHECK && !redundant && !fail_rise && !lock_rise |=> !cf_reg && !lock_reg)
      else $error("flags not cleared on valid switch");
   chk_wait_ready: assert property (
      state_reg == ST_WAIT && !tgt_ready |=> state_reg == ST_WAIT)
      else $error("left wait before source ready");
   chk_ten_edges: assert property (
      state_reg == ST_COUNT ##1 state_reg == ST_DONE |-> $past(cnt_reg) == CNT_W'(NEW_CLK_COUNT - 1))
      else $error("changeover not after ten edges");
   chk_copy_source: assert property (
      state_reg == ST_DONE |=> cur_reg == $past(tgt_reg) && !req_reg && o_clk_sel == $past(tgt_reg))
      else $error("changeover did not copy source");
   chk_tune_locked: assert property (
      self_tune_enable_reg && wr_tune_lo && !up_rise && !dn_rise |=> tune_reg == $past(tune_reg))
      else $error("tuning written during self-tune");
   chk_tune_signed: assert property (
      $past(tune_reg) == TUNE_MIN |-> tune_reg != TUNE_MAX)
      else $error("tuning wrapped past minimum");
   chk_broken_keys: assert property (
      wr_ctrl_hi && hi_key_reg != KEY_OPEN && !cfg_load |=> new_reg == $past(new_reg))
      else $error("high byte written without unlock");

   cov_redundant: cover property (state_reg == ST_CHECK && redundant);
   cov_full_switch: cover property (state_reg == ST_DONE);
   cov_pll_switch: cover property (state_reg == ST_DONE && uses_pll(tgt_reg));
   cov_self_tune: cover property (self_tune_enable_reg && up_rise);

endmodule // osw_osc_switch

// >>> sim/tb.sv
`timescale 1ns/100ps
// compare, count, report a mismatch
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value at %0t: got %h, expected %h", $time, g, e); end end
module tb
   import osw_pkg::*;
   ;
   // bench drive and design outputs
   logic       i_clk_sys = 1'b0;
   logic       i_reset   = 1'b1;
   logic       i_wr      = 1'b0;
   logic       i_rd      = 1'b0;
   logic       tune_up   = 1'b0;
   logic       tune_dn   = 1'b0;
   logic       pll_lock  = 1'b1;
   logic       fail      = 1'b0;
   logic [1:0] addr      = 2'h0;
   logic [1:0] mon_cfg   = 2'h0;
   logic [1:0] ndiv      = 2'h0;
   logic [7:0] wdata     = 8'h00;
   logic [2:0] init_cfg  = 3'h0;
   logic [3:0] stable    = 4'hF;
   logic [7:0] rdata, d;
   logic [2:0] clk_sel;
   logic [3:0] osc_en;
   logic [5:0] rc_tune;
   // reference model state
   int         mismatches = 0, n_checks = 0, cycles = 0, cur = 0, nxt = 0, t, k;
   int         tg[6] = '{SRC_PRI, SRC_SEC, SRC_LOW_POWER_RC, SRC_FRC_PLL, SRC_FRC, SRC_FRC};

   osw_osc_switch #(.NEW_CLK_COUNT(10)) DUT (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(addr), .i_wdata(wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_switch_monitor_cfg(mon_cfg),
      .i_initial_source_cfg(init_cfg), .i_primary_submode_cfg(2'h1), .i_watchdog_en(1'b0),
      .i_osc_stable(stable), .i_pll_lock(pll_lock), .i_new_clk(ndiv[1]), .i_clk_fail(fail),
      .i_tune_up(tune_up), .i_tune_dn(tune_dn), .o_clk_sel(clk_sel), .o_new_clk_sel(),
      .o_osc_en(osc_en), .o_pll_en(), .o_primary_submode(), .o_rc_tune(rc_tune),
      .o_switch_busy());

   always #20 i_clk_sys = ~i_clk_sys;

   // new source clock, a quarter of the system rate; watchdog on the run
   always @(posedge i_clk_sys) begin
      ndiv <= ndiv + 2'h1;
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         end_of_test();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask

   // write strobe left high so writes run back to back
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge i_clk_sys);
      i_wr  <= 1'b1;
      i_rd  <= 1'b0;
      addr  <= a;
      wdata <= v;
   endtask

   task automatic idle();
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [1:0] a);
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
      i_rd <= 1'b1;
      addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 d = rdata;
   endtask

   // fail event pulse, then read the flag back
   task automatic fail_pulse();
      @(posedge i_clk_sys);
      fail <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      fail <= 1'b0;
      cyc(4);
      rd(ADDR_CTRL_LO);
   endtask

   // high unlock pair, new source, low unlock pair, then the request
   // nothing interleaves unlock
   task automatic keys(input logic [2:0] s);
      wr(ADDR_CTRL_HI, KEY_HI_1);
      wr(ADDR_CTRL_HI, KEY_HI_2);
      wr(ADDR_CTRL_HI, {5'h00, s});
      wr(ADDR_CTRL_LO, KEY_LO_1);
      wr(ADDR_CTRL_LO, KEY_LO_2);
      wr(ADDR_CTRL_LO, 8'h01);
      idle();
   endtask

   function automatic int oidx(input int s);
      return (s == SRC_PRI || s == SRC_PRI_PLL) ? OSC_PRI : (s == SRC_SEC) ? OSC_SEC :
             (s == SRC_LOW_POWER_RC) ? OSC_LOW_POWER_RC : OSC_FRC;
   endfunction

   task automatic sw(input int s);
      int old;
      int slow;
      old  = cur;
      slow = (s == SRC_PRI || s == SRC_SEC || s == SRC_FRC_PLL);
      // hold crystal and pll targets unready so the wait is visible
      @(posedge i_clk_sys);
      if (slow) begin
         stable   <= 4'h0;
         pll_lock <= 1'b0;
      end
      cyc(4);
      keys(s[2:0]);
      nxt = s;
      if (s == cur) begin
         cyc(4);
         rd(ADDR_CTRL_LO);
         `CHK(d[0], 1'b0)
         `CHK(clk_sel, cur[2:0])
      end else begin
         if (slow) begin
            cyc(20);
            `CHK(clk_sel, old[2:0])
            @(posedge i_clk_sys);
            stable   <= 4'hF;
            pll_lock <= 1'b1;
         end
         k = 0;
         while (clk_sel !== s[2:0] && k < 300) begin
            cyc(1);
            k++;
         end
         `CHK(k >= 36, 1'b1)
         `CHK(clk_sel, s[2:0])
         cur = s;
         cyc(2);
         `CHK(osc_en[oidx(s)], 1'b1)
         if (old == SRC_PRI || old == SRC_SEC) `CHK(osc_en[oidx(old)], 1'b0)
         rd(ADDR_CTRL_LO);
         `CHK(d, {2'h0, slow[0], 5'h00})
         rd(ADDR_CTRL_HI);
         `CHK(d, {1'b0, cur[2:0], 1'b0, nxt[2:0]})
      end
      $display("test switch to %0d done", s);
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      void'($urandom(32'h1325));
      repeat (5) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      cyc(6);
      `CHK(clk_sel, SRC_FRC)
      fail_pulse();
      `CHK(d[CF_BIT], 1'b1)
      foreach (tg[i]) sw(tg[i]);
      // broken key order must leave the byte locked
      wr(ADDR_CTRL_HI, KEY_HI_2);
      wr(ADDR_CTRL_HI, KEY_HI_1);
      wr(ADDR_CTRL_HI, 8'h04);
      idle();
      rd(ADDR_CTRL_HI);
      `CHK(d[2:0], nxt[2:0])
      $display("test lock done");
      // tuning field, then self-tune takes it over
      t = $urandom % 31;
      wr(ADDR_TUNE_LO, t[7:0]);
      idle();
      cyc(1);
      `CHK(rc_tune, t[5:0])
      wr(ADDR_TUNE_HI, 8'h80);
      wr(ADDR_TUNE_LO, ~t[7:0]);
      idle();
      cyc(1);
      `CHK(rc_tune, t[5:0])
      @(posedge i_clk_sys);
      tune_up <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      tune_up <= 1'b0;
      cyc(6);
      rd(ADDR_TUNE_LO);
      `CHK(d, {2'h0, t[5:0] + 6'h01})
      @(posedge i_clk_sys);
      tune_dn <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      tune_dn <= 1'b0;
      cyc(6);
      rd(ADDR_TUNE_LO);
      `CHK(d, {2'h0, t[5:0]})
      $display("test tune done");
      // second reset with switching left off
      @(posedge i_clk_sys);
      i_reset  <= 1'b1;
      mon_cfg  <= 2'h3;
      init_cfg <= SRC_LOW_POWER_RC;
      repeat (5) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      cyc(8);
      `CHK(clk_sel, SRC_LOW_POWER_RC)
      fail_pulse();
      `CHK(d[CF_BIT], 1'b0)
      keys(SRC_PRI);
      rd(ADDR_CTRL_LO);
      `CHK(d[0], 1'b0)
      cyc(60);
      `CHK(clk_sel, SRC_LOW_POWER_RC)
      rd(ADDR_CTRL_HI);
      `CHK(d[6:4], SRC_LOW_POWER_RC)
      $display("test disabled done");
      end_of_test();
   end
endmodule // tb
